// File: sim/host_model.sv
// host side model issuing register writes and reads
`default_nettype none
module host_model (
    input  wire logic        clk,
    input  wire logic [15:0] rdata,
    output logic             wr_en,
    output logic             rd_en,
    output logic      [7:0]  addr,
    output logic      [15:0] wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wr_en, rd_en, addr, wdata} = 26'h0;
    // request held to its sampling edge; released data inverted, not left stale
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        wdata <= ~d;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask : rd
endmodule : host_model
`default_nettype wire

// File: sim/system_config_state_regs_asserts.sv
// port-level checker for the system configuration registers
`default_nettype none
module system_config_state_regs_asserts (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        wsm_reset,
    input wire logic        safing_reset,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [7:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        write_allowed,
    input wire logic [2:0]  operating_phase,
    input wire logic [15:0] rdata,
    input wire logic        write_denied_error,
    input wire logic        soft_reset_pulse,
    input wire logic        high_level_test_duration,
    input wire logic        sensor_sync_shift_select,
    input wire logic [4:0]  loop_sample_count,
    input wire logic [4:0]  voltage_sample_count,
    input wire logic        pulldown_leak_level_select,
    input wire logic        supply_threshold_select
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic calm, wcfg, wctl;
    // any reset source would override a write in the same cycle
    assign calm = !wsm_reset && !safing_reset && !soft_reset_pulse;
    assign wcfg = calm && wr_en && write_allowed && addr == system_configuration_pkg::ADDR_CONFIG;
    assign wctl = calm && wr_en && write_allowed && addr == system_configuration_pkg::ADDR_CONTROL;
    AST_CFG_BITS: assert property (wcfg |=> {high_level_test_duration,
        sensor_sync_shift_select} == $past(wdata[10:9])) else $error("diag or shift bit");
    AST_LOOP_CODE: assert property (wcfg && wdata[8:7] == 2'h3
        |=> loop_sample_count == 5'h02) else $error("loop count");
    AST_VOLT_CODE: assert property (wcfg && wdata[6:5] == 2'h1
        |=> voltage_sample_count == 5'h10) else $error("voltage count");
    AST_CTL_BITS: assert property (wctl |=> {pulldown_leak_level_select,
        supply_threshold_select} == {$past(wdata[14]), $past(wdata[12])}) else $error("ctl bits");
    AST_SAFING: assert property (safing_reset |=> loop_sample_count == 5'h08
        && voltage_sample_count == 5'h04 && !supply_threshold_select) else $error("safing clear");
    AST_DENY: assert property (calm && wr_en && !write_allowed |=> write_denied_error)
        else $error("denied write not flagged");
    AST_SOFT: assert property (wr_en && write_allowed && calm && addr == 8'h03
        |=> soft_reset_pulse ##1 !soft_reset_pulse) else $error("soft reset pulse");
    AST_PHASE: assert property (rd_en && addr == 8'h04 && calm && $past(calm)
        && !$past(sys_rst) && $stable(operating_phase)
        |=> rdata == {5'h00, $past(operating_phase), 8'h00}) else $error("phase report");
    cover property (wcfg);
    cover property (safing_reset);
    cover property (wr_en && !write_allowed);
    cover property (soft_reset_pulse);
endmodule : system_config_state_regs_asserts
bind system_config_state_regs system_config_state_regs_asserts u_asserts (.clk, .sys_rst,
    .wsm_reset, .safing_reset, .wr_en, .rd_en, .addr, .wdata, .write_allowed, .operating_phase,
    .rdata, .write_denied_error, .soft_reset_pulse, .high_level_test_duration,
    .sensor_sync_shift_select, .loop_sample_count, .voltage_sample_count,
    .pulldown_leak_level_select, .supply_threshold_select);
`default_nettype wire

// File: sim/system_config_state_regs_tb.sv
// self-checking bench for the system configuration registers
`default_nettype none
module system_config_state_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, sys_rst = 1'b1, wsm_reset = 1'b0, safing_reset = 1'b0;
    logic        frame_done = 1'b0, write_allowed = 1'b1, meas_done = 1'b0;
    logic        global_lowside_enable_input = 1'b0, highside_enable = 1'b0;
    logic [2:0]  operating_phase = 3'h0;
    logic        wr_en, rd_en, write_denied_error, soft_reset_pulse, measure_power_on;
    logic        high_level_test_duration, sensor_sync_shift_select, lowside_enable;
    logic        pulldown_leak_level_select, supply_threshold_select;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, rv;
    logic [4:0]  loop_sample_count, voltage_sample_count;
    logic [4:0]  lexp [4] = '{5'h08, 5'h10, 5'h04, 5'h02};
    logic [4:0]  vexp [4] = '{5'h04, 5'h10, 5'h08, 5'h01};
    int          err_count = 0, n_checks = 0;
    always #2 clk = ~clk;
    system_config_state_regs dut (.clk, .sys_rst, .wsm_reset, .safing_reset, .frame_done,
        .wr_en, .rd_en, .addr, .wdata, .write_allowed, .operating_phase, .meas_done,
        .global_lowside_enable_input, .highside_enable, .rdata, .write_denied_error,
        .soft_reset_pulse, .measure_power_on, .high_level_test_duration,
        .sensor_sync_shift_select, .loop_sample_count, .voltage_sample_count, .lowside_enable,
        .pulldown_leak_level_select, .supply_threshold_select);
    host_model host (.clk, .rdata, .wr_en, .rd_en, .addr, .wdata);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    // hang guard, far beyond the fewer than a hundred cycles the sequence needs
    initial begin
        #20000;
        err_count++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 1; a < 6; a++) begin
            host.rd(8'(a), rv);
            chk(rv, 16'h0000);
        end
        chk(16'(measure_power_on), 16'h1);
        host.wr(8'h01, 16'hFFFF);
        chk(16'({high_level_test_duration, sensor_sync_shift_select}), 16'h3);
        host.rd(8'h01, rv);
        chk(rv, 16'h87E8);
        // same code placed in both count fields
        for (int c = 0; c < 4; c++) begin
            host.wr(8'h01, 16'(c * 16'hA0));
            chk(16'(loop_sample_count), 16'(lexp[c]));
            chk(16'(voltage_sample_count), 16'(vexp[c]));
        end
        host.wr(8'h01, 16'h81E8);
        @(posedge clk) global_lowside_enable_input <= 1'b1;
        @(posedge clk) meas_done <= 1'b1;
        @(posedge clk) meas_done <= 1'b0;
        #1 chk(16'({lowside_enable, measure_power_on}), 16'h2);
        @(posedge clk) safing_reset <= 1'b1;
        @(posedge clk) safing_reset <= 1'b0;
        #1 chk(16'({lowside_enable, loop_sample_count, voltage_sample_count}), 16'h104);
        chk(16'(measure_power_on), 16'h1);
        host.wr(8'h02, 16'hFFFF);
        chk(16'({pulldown_leak_level_select, supply_threshold_select}), 16'h3);
        @(posedge clk) write_allowed <= 1'b0;
        host.wr(8'h02, 16'h0000);
        @(posedge clk) write_allowed <= 1'b1;
        #1 chk(16'(write_denied_error), 16'h1);
        host.rd(8'h02, rv);
        chk(rv, 16'h5000);
        @(posedge clk) frame_done <= 1'b1;
        @(posedge clk) frame_done <= 1'b0;
        #1 chk(16'(write_denied_error), 16'h0);
        @(posedge clk) wsm_reset <= 1'b1;
        @(posedge clk) wsm_reset <= 1'b0;
        host.rd(8'h02, rv);
        chk(rv, 16'h0000);
        host.wr(8'h02, 16'h5000);
        host.wr(8'h03, 16'hFFFF);
        chk(16'(soft_reset_pulse), 16'h1);
        @(posedge clk);
        #1 chk(16'({soft_reset_pulse, pulldown_leak_level_select}), 16'h0);
        for (int p = 0; p < 3; p++) begin
            @(posedge clk) operating_phase <= 3'(p);
            host.rd(8'h04, rv);
            chk(rv, 16'(p) << 8);
        end
        close_out();
    end
endmodule : system_config_state_regs_tb
`default_nettype wire

// File: verilog/sample_count_decode.sv
// decodes the two sample-count codes into sample numbers
`default_nettype none
module sample_count_decode (
    input  wire logic [1:0] loop_code,
    input  wire logic [1:0] volt_code,
    output logic      [4:0] loop_samples,
    output logic      [4:0] volt_samples
);
    // code order is not monotonic, so a table and not a shift
    always_comb begin
        unique case (loop_code)
            2'h0: loop_samples = system_configuration_pkg::LOOP_N0;
            2'h1: loop_samples = system_configuration_pkg::LOOP_N1;
            2'h2: loop_samples = system_configuration_pkg::LOOP_N2;
            2'h3: loop_samples = system_configuration_pkg::LOOP_N3;
        endcase
        unique case (volt_code)
            2'h0: volt_samples = system_configuration_pkg::VOLT_N0;
            2'h1: volt_samples = system_configuration_pkg::VOLT_N1;
            2'h2: volt_samples = system_configuration_pkg::VOLT_N2;
            2'h3: volt_samples = system_configuration_pkg::VOLT_N3;
        endcase
    end
endmodule : sample_count_decode
`default_nettype wire

// File: verilog/system_config_state_regs.sv
// system configuration, control, soft reset and phase report registers
`default_nettype none
// Notes on behaviour
// - set bit 15 auto-stops measurement source
// - bit 10 picks short or long diagnostics
// - bit 9 picks long or short shift
// - bits 8:7 pick loop sample count
// - bits 6:5 pick voltage sample count
// - sample fields, lowside option cleared by safing reset
// - bit 3 lets global input enable lowsides
// - control bit 14 picks pull-down level
// - control bit 12 picks supply threshold
// - phase report in bits 10:8
// - all fields cleared by every reset, except the error flag under safing reset
// - forbidden write flags error next frame
module system_config_state_regs (
    // clock and reset sources
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        wsm_reset,
    input  wire logic        safing_reset,
    // frame boundary and register access
    input  wire logic        frame_done,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        write_allowed,
    // live status from the rest of the device
    input  wire logic [2:0]  operating_phase,
    input  wire logic        meas_done,
    input  wire logic        global_lowside_enable_input,
    input  wire logic        highside_enable,
    // read data and status
    output logic      [15:0] rdata,
    output logic             write_denied_error,
    output logic             soft_reset_pulse,
    output logic             measure_power_on,
    // configuration fields
    output logic             high_level_test_duration,
    output logic             sensor_sync_shift_select,
    output logic      [4:0]  loop_sample_count,
    output logic      [4:0]  voltage_sample_count,
    output logic             lowside_enable,
    output logic             pulldown_leak_level_select,
    output logic             supply_threshold_select
);
    // register state
    logic [15:0] config_ff;
    logic [15:0] control_ff;
    logic [2:0]  phase_ff;
    logic        meas_on_ff;
    logic        denied_ff;
    logic        soft_ff;

    // request decode
    logic        cfg_wr;
    logic        ctl_wr;
    logic        soft_wr;
    logic        deny_wr;

    // clear terms and events
    logic        hard_clr;
    logic        field_clr;
    logic        meas_off_evt;

    // masked write words
    logic [15:0] cfg_wdata;
    logic [15:0] ctl_wdata;

    // named views of the stored fields
    logic        auto_off_en;
    logic        gls_option;
    logic [1:0]  loop_code;
    logic [1:0]  volt_code;

    // read path
    logic [15:0] phase_word;
    logic [15:0] nxt_rdata;

    // address decode; a refused write never reaches a register
    assign cfg_wr   = wr_en && write_allowed && addr == system_configuration_pkg::ADDR_CONFIG;
    assign ctl_wr   = wr_en && write_allowed && addr == system_configuration_pkg::ADDR_CONTROL;
    assign soft_wr  = wr_en && write_allowed && addr == system_configuration_pkg::ADDR_SOFT_RST;
    assign deny_wr  = wr_en && !write_allowed;

    // soft reset acts like the other internal resets, one cycle late
    assign hard_clr  = sys_rst || wsm_reset || soft_ff;
    // safing clears the same fields but leaves the error flag alone
    assign field_clr = hard_clr || safing_reset;

    // reserved positions dropped before storage, so they always read zero
    assign cfg_wdata = wdata & system_configuration_pkg::CFG_MASK;
    assign ctl_wdata = wdata & system_configuration_pkg::CTL_MASK;

    // field views keep the bit positions in one place
    assign auto_off_en = config_ff[system_configuration_pkg::CFG_AUTO_OFF];
    assign gls_option  = config_ff[system_configuration_pkg::CFG_GLS_OPT];
    assign loop_code   = config_ff[system_configuration_pkg::CFG_LOOP_HI:system_configuration_pkg::CFG_LOOP_LO];
    assign volt_code   = config_ff[system_configuration_pkg::CFG_VOLT_HI:system_configuration_pkg::CFG_VOLT_LO];

    // auto-off only bites once a measurement reports done
    assign meas_off_evt = meas_done && auto_off_en;

    // configuration register; safing clears every field, sample ones included
    // a write in the same cycle as any reset is lost, the reset wins
    always_ff @(posedge clk) begin
        if (field_clr) begin
            config_ff <= system_configuration_pkg::REG_RESET;
        end else if (cfg_wr) begin
            config_ff <= cfg_wdata;
        end
    end

    // control register
    // pull-down and threshold fall back to the low settings on any reset
    always_ff @(posedge clk) begin
        if (field_clr) begin
            control_ff <= system_configuration_pkg::REG_RESET;
        end else if (ctl_wr) begin
            control_ff <= ctl_wdata;
        end
    end

    // soft reset command pulse, registered to avoid a combinational reset path
    // the pulse clears itself, so a held write cannot lock the logic in reset
    always_ff @(posedge clk) begin
        if (sys_rst || soft_ff) begin
            soft_ff <= 1'b0;
        end else begin
            soft_ff <= soft_wr;
        end
    end

    // phase snapshot for the report register, one cycle behind the live phase
    // a clear lasts one cycle; the live input takes over after it
    always_ff @(posedge clk) begin
        if (field_clr) begin
            phase_ff <= system_configuration_pkg::PHASE_INIT;
        end else begin
            phase_ff <= operating_phase;
        end
    end

    // measurement source: on at reset, turned off after a measurement if enabled
    // with auto-off clear the source comes straight back on
    always_ff @(posedge clk) begin
        if (field_clr) begin
            meas_on_ff <= 1'b1;
        end else if (meas_off_evt) begin
            meas_on_ff <= 1'b0;
        end else if (!auto_off_en) begin
            meas_on_ff <= 1'b1;
        end
    end

    // denied write flag stands for the next frame; a new denial wins over the frame_done clear
    // safing leaves the flag alone; besides frame_done, only the internal resets clear it
    always_ff @(posedge clk) begin
        if (hard_clr) begin
            denied_ff <= 1'b0;
        end else if (deny_wr) begin
            denied_ff <= 1'b1;
        end else if (frame_done) begin
            denied_ff <= 1'b0;
        end
    end

    // phase report word: code in its field, all else zero
    always_comb begin
        phase_word = system_configuration_pkg::REG_RESET;
        phase_word[system_configuration_pkg::PHASE_LO +: $bits(phase_ff)] = phase_ff;
    end

    // read mux; soft reset address and unmapped read as zero
    // zeros rather than stale data, so a bad address is easy to spot
    always_comb begin
        nxt_rdata = system_configuration_pkg::REG_RESET;
        unique case (addr)
            system_configuration_pkg::ADDR_CONFIG:  nxt_rdata = config_ff;
            system_configuration_pkg::ADDR_CONTROL: nxt_rdata = control_ff;
            system_configuration_pkg::ADDR_PHASE:   nxt_rdata = phase_word;
            default:                   nxt_rdata = system_configuration_pkg::REG_RESET;
        endcase
    end

    // read data registered on the read strobe and held until the next one
    // soft and wsm resets leave the last read word standing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= system_configuration_pkg::REG_RESET;
        end else if (rd_en) begin
            rdata <= nxt_rdata;
        end
    end

    // sample counts decoded in a small table module
    // counts follow the stored codes directly, no extra latency
    sample_count_decode u_decode (
        .loop_code    (loop_code),
        .volt_code    (volt_code),
        .loop_samples (loop_sample_count),
        .volt_samples (voltage_sample_count)
    );

    // status and pulse outputs straight from their flip-flops
    assign write_denied_error         = denied_ff;
    assign soft_reset_pulse           = soft_ff;
    assign measure_power_on           = meas_on_ff;

    // single-bit field outputs
    assign high_level_test_duration   = config_ff[system_configuration_pkg::CFG_HI_TIME];
    assign sensor_sync_shift_select   = config_ff[system_configuration_pkg::CFG_SYNC_SH];
    assign pulldown_leak_level_select = control_ff[system_configuration_pkg::CTL_PD_SEL];
    assign supply_threshold_select    = control_ff[system_configuration_pkg::CTL_SAT_SEL];

    // low sides follow the global input only when the option is set;
    // otherwise each low side waits for its own high side
    assign lowside_enable = gls_option
                          ? global_lowside_enable_input
                          : highside_enable;
endmodule : system_config_state_regs
`default_nettype wire

// File: verilog/system_configuration_pkg.sv
// constants for the system configuration and phase report registers
`default_nettype none
package system_configuration_pkg;
    localparam logic [7:0]  ADDR_CONFIG   = 8'h01;
    localparam logic [7:0]  ADDR_CONTROL  = 8'h02;
    localparam logic [7:0]  ADDR_SOFT_RST = 8'h03;
    localparam logic [7:0]  ADDR_PHASE    = 8'h04;
    localparam int          CFG_AUTO_OFF  = 15;
    localparam int          CFG_HI_TIME   = 10;
    localparam int          CFG_SYNC_SH   = 9;
    localparam int          CFG_LOOP_HI   = 8;
    localparam int          CFG_LOOP_LO   = 7;
    localparam int          CFG_VOLT_HI   = 6;
    localparam int          CFG_VOLT_LO   = 5;
    localparam int          CFG_GLS_OPT   = 3;
    localparam int          CTL_PD_SEL    = 14;
    localparam int          CTL_SAT_SEL   = 12;
    localparam int          PHASE_LO      = 8;
    localparam logic [15:0] CFG_MASK      = 16'h87E8;
    localparam logic [15:0] CTL_MASK      = 16'h5000;
    localparam logic [15:0] REG_RESET     = 16'h0000;
    localparam logic [2:0]  PHASE_INIT    = 3'h0;
    localparam logic [2:0]  PHASE_DIAG    = 3'h1;
    localparam logic [2:0]  PHASE_SAFING  = 3'h2;
    // sample counts per code
    localparam logic [4:0]  LOOP_N0 = 5'h08;
    localparam logic [4:0]  LOOP_N1 = 5'h10;
    localparam logic [4:0]  LOOP_N2 = 5'h04;
    localparam logic [4:0]  LOOP_N3 = 5'h02;
    localparam logic [4:0]  VOLT_N0 = 5'h04;
    localparam logic [4:0]  VOLT_N1 = 5'h10;
    localparam logic [4:0]  VOLT_N2 = 5'h08;
    localparam logic [4:0]  VOLT_N3 = 5'h01;
endpackage : system_configuration_pkg
`default_nettype wire
